// file: src/wiper_store_ctrl.sv
// Top of the dual wiper setting store control.
`timescale 1ns/100ps
`default_nettype none
`include "wiper_store_defines.svh"

// Functional notes
// - A frame is a 16-bit word of instruction, address and data, and only whole words are decoded.
// - Code zero puts the wiper at terminal B, midscale at the middle and all ones at terminal A.
// - Instruction 11 loads the data byte into the addressed wiper position register, any number of times.
// - Instruction 2 copies the addressed wiper position into that channel's nonvolatile store.
// - A save takes about 25 ms and the shift register is locked for all of it.
// - The ready output shows the end of a save.
// - After power-on each wiper is loaded from its store, which starts at midscale.
// - A low preset forces midscale and its rising edge, unless it comes during a save, reloads the wiper from the store.
// - Increment and decrement move one step, shifts move by 6 dB.
// - After a step or shift command, each empty select strobe repeats it.
// - Write protect blocks every change to the wipers but still allows refresh and preset.
// - Address selects the channel and the serial output carries the previous frame.
// - A frame is executed only when select returns high.
// - The serial output shows the input delayed by 16 clocks for daisy chains.
module wiper_store_ctrl #(
   parameter int unsigned SAVE_CYCLES = `SAVE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo_o,
   output logic sdo_oe,
   // Control pins
   input wire logic wp_n,
   input wire logic preset_reload_n,
   // Ready pin, open drain
   output logic rdy_o,
   output logic rdy_oe,
   // Wiper taps
   output wiper_store_pkg::wiper_t wiper_tap_ch1,
   output wiper_store_pkg::wiper_t wiper_tap_ch2
);

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic wiper_store_pkg::wiper_t step_wiper(
      input logic [3:0] op,
      input wiper_store_pkg::wiper_t cur,
      input wiper_store_pkg::wiper_t data
   );
      step_wiper = cur;
      case (op)
         `OP_WRITE: begin
            step_wiper = data;
         end
         `OP_INC_ONE, `OP_INC_ALL: begin
            if (cur != `WIPER_FULL) begin
               step_wiper = cur + 8'h01;
            end
         end
         `OP_DEC_ONE, `OP_DEC_ALL: begin
            if (cur != `WIPER_ZERO) begin
               step_wiper = cur - 8'h01;
            end
         end
         `OP_SHL_ONE, `OP_SHL_ALL: begin
            step_wiper = cur[7] ? `WIPER_FULL : {cur[6:0], 1'b0};
         end
         `OP_SHR_ONE, `OP_SHR_ALL: begin
            step_wiper = {1'b0, cur[7:1]};
         end
         default: begin
            step_wiper = cur;
         end
      endcase
   endfunction

   function automatic logic is_repeatable(input logic [3:0] op);
      case (op)
         `OP_INC_ONE, `OP_INC_ALL, `OP_DEC_ONE, `OP_DEC_ALL,
         `OP_SHL_ONE, `OP_SHL_ALL, `OP_SHR_ONE, `OP_SHR_ALL: begin
            is_repeatable = 1'b1;
         end
         default: begin
            is_repeatable = 1'b0;
         end
      endcase
   endfunction

   function automatic logic hits_channel(
      input logic [3:0] op,
      input logic [3:0] addr,
      input logic [3:0] ch
   );
      case (op)
         `OP_INC_ALL, `OP_DEC_ALL, `OP_SHL_ALL, `OP_SHR_ALL, `OP_REFRESH_ALL: begin
            hits_channel = 1'b1;
         end
         default: begin
            hits_channel = (addr == ch);
         end
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   frame_if frm ();

   wiper_store_pkg::wiper_t store_ch1;
   wiper_store_pkg::wiper_t store_ch2;
   logic store_busy;
   logic store_done;
   logic store_wr;
   logic store_sel;
   wiper_store_pkg::wiper_t store_data;

   serial_frontend u_front (
      .core_clk(core_clk),
      .resetn(resetn),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .sdo_o(sdo_o),
      .sdo_oe(sdo_oe),
      .frm(frm.front)
   );

   setting_store #(
      .SAVE_CYCLES(SAVE_CYCLES)
   ) u_store (
      .core_clk(core_clk),
      .resetn(resetn),
      .wr_en(store_wr),
      .wr_sel(store_sel),
      .wr_data(store_data),
      .rd_ch1(store_ch1),
      .rd_ch2(store_ch2),
      .busy(store_busy),
      .done(store_done)
   );

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] wp_sync_q;
   logic [2:0] pr_sync_q;
   logic protect;
   logic preset_low;
   logic preset_rise;

   always_ff @(posedge core_clk) begin
      wp_sync_q <= {wp_sync_q[0], wp_n};
   end

   always_ff @(posedge core_clk) begin
      pr_sync_q <= {pr_sync_q[1:0], preset_reload_n};
   end

   assign protect = !wp_sync_q[1];
   assign preset_low = !pr_sync_q[1];
   assign preset_rise = pr_sync_q[1] && !pr_sync_q[2];

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   wiper_store_pkg::ctrl_state_e state_q;
   logic [15:0] last_word_q;
   logic [15:0] cmd_word;
   logic [3:0] op;
   logic [3:0] addr;
   wiper_store_pkg::wiper_t data;
   logic exec;
   logic moves_wiper;
   logic save_go;

   always_comb begin
      cmd_word = frm.repeat_req ? last_word_q : frm.word;
      op = cmd_word[`CMD_MSB:`CMD_LSB];
      addr = cmd_word[`ADDR_MSB:`ADDR_LSB];
      data = cmd_word[`DATA_MSB:`DATA_LSB];
      exec = (state_q == wiper_store_pkg::ST_IDLE) && !preset_low &&
             (frm.frame_done || (frm.repeat_req && is_repeatable(op)));
      moves_wiper = (op == `OP_WRITE) || is_repeatable(op);
      save_go = 1'b0;
      store_sel = addr[0];
      store_data = data;
      if (exec && !protect) begin
         if (op == `OP_SAVE && (addr == `ADDR_CH1 || addr == `ADDR_CH2)) begin
            save_go = 1'b1;
            store_data = addr[0] ? wiper_tap_ch2 : wiper_tap_ch1;
         end else if (op == `OP_STORE_DATA &&
                      (addr == `ADDR_CH1 || addr == `ADDR_CH2)) begin
            save_go = 1'b1;
         end
      end
   end

   assign store_wr = save_go;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         last_word_q <= 16'h0000;
      end else if (exec && frm.frame_done) begin
         last_word_q <= frm.word;
      end
   end

   // ----------------------------------------------------------------
   // Control state machine
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         state_q <= wiper_store_pkg::ST_BOOT;
      end else begin
         case (state_q)
            wiper_store_pkg::ST_BOOT: begin
               state_q <= wiper_store_pkg::ST_IDLE;
            end
            wiper_store_pkg::ST_IDLE: begin
               if (preset_low) begin
                  state_q <= wiper_store_pkg::ST_PRESET;
               end else if (save_go) begin
                  state_q <= wiper_store_pkg::ST_SAVE;
               end
            end
            wiper_store_pkg::ST_SAVE: begin
               if (store_done) begin
                  state_q <= wiper_store_pkg::ST_IDLE;
               end
            end
            wiper_store_pkg::ST_PRESET: begin
               if (preset_rise) begin
                  state_q <= wiper_store_pkg::ST_BOOT;
               end
            end
            default: begin
               state_q <= wiper_store_pkg::ST_BOOT;
            end
         endcase
      end
   end

   // Shift register stays frozen from the save request to its end.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         frm.lock <= 1'b0;
      end else if (save_go) begin
         frm.lock <= 1'b1;
      end else if (store_done) begin
         frm.lock <= 1'b0;
      end
   end

   // Ready is pulled low during a save and released when it ends.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rdy_oe <= 1'b0;
         rdy_o <= 1'b0;
      end else if (save_go) begin
         rdy_oe <= 1'b1;
      end else if (store_done) begin
         rdy_oe <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Wiper position registers
   // ----------------------------------------------------------------
   wiper_store_pkg::wiper_t wiper1_q;
   wiper_store_pkg::wiper_t wiper2_q;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wiper1_q <= `WIPER_MID;
         wiper2_q <= `WIPER_MID;
      end else if (state_q == wiper_store_pkg::ST_BOOT) begin
         wiper1_q <= store_ch1;
         wiper2_q <= store_ch2;
      end else if (state_q == wiper_store_pkg::ST_PRESET || preset_low) begin
         wiper1_q <= `WIPER_MID;
         wiper2_q <= `WIPER_MID;
      end else if (exec) begin
         if (op == `OP_REFRESH || op == `OP_REFRESH_ALL) begin
            if (hits_channel(op, addr, `ADDR_CH1)) begin
               wiper1_q <= store_ch1;
            end
            if (hits_channel(op, addr, `ADDR_CH2)) begin
               wiper2_q <= store_ch2;
            end
         end else if (moves_wiper && !protect) begin
            if (hits_channel(op, addr, `ADDR_CH1)) begin
               wiper1_q <= step_wiper(op, wiper1_q, data);
            end
            if (hits_channel(op, addr, `ADDR_CH2)) begin
               wiper2_q <= step_wiper(op, wiper2_q, data);
            end
         end
      end
   end

   // Tap code: zero at terminal B, midscale in the middle, all ones at A.
   assign wiper_tap_ch1 = wiper1_q;
   assign wiper_tap_ch2 = wiper2_q;

endmodule // wiper_store_ctrl

`default_nettype wire

// file: src/wiper_store_defines.svh
// Constants of the dual wiper setting store control.
`ifndef WIPER_STORE_DEFINES_SVH
`define WIPER_STORE_DEFINES_SVH

// ----------------------------------------------------------------
// Serial word layout
// ----------------------------------------------------------------
`define WORD_BITS 16
`define WORD_MSB 15
`define CMD_MSB 15
`define CMD_LSB 12
`define ADDR_MSB 11
`define ADDR_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0
`define BIT_CNT_W 8

// ----------------------------------------------------------------
// Wiper codes and channel addresses
// ----------------------------------------------------------------
`define WIPER_ZERO 8'h00
`define WIPER_MID 8'h80
`define WIPER_FULL 8'hFF
`define ADDR_CH1 4'h0
`define ADDR_CH2 4'h1

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define OP_NOP 4'h0
`define OP_REFRESH 4'h1
`define OP_SAVE 4'h2
`define OP_STORE_DATA 4'h3
`define OP_SHR_ONE 4'h4
`define OP_SHR_ALL 4'h5
`define OP_DEC_ONE 4'h6
`define OP_DEC_ALL 4'h7
`define OP_REFRESH_ALL 4'h8
`define OP_WRITE 4'hB
`define OP_SHL_ONE 4'hC
`define OP_SHL_ALL 4'hD
`define OP_INC_ONE 4'hE
`define OP_INC_ALL 4'hF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SAVE_TIME_MS 25
`define CORE_CLK_KHZ 100000
`define SAVE_CYCLES (`SAVE_TIME_MS * `CORE_CLK_KHZ)

`endif

// file: src/wiper_store_pkg.sv
// Types shared by the dual wiper setting store control.
package wiper_store_pkg;

   typedef logic [7:0] wiper_t;

   typedef enum logic [3:0] {
      ST_BOOT = 4'h1,
      ST_IDLE = 4'h2,
      ST_SAVE = 4'h4,
      ST_PRESET = 4'h8
   } ctrl_state_e;

endpackage

// file: src/frame_if.sv
// Hand-over of received serial frames between front end and controller.
`timescale 1ns/100ps
`default_nettype none

interface frame_if;
   logic [15:0] word;
   logic frame_done;
   logic repeat_req;
   logic lock;

   modport front (output word, output frame_done, output repeat_req, input lock);
   modport core (input word, input frame_done, input repeat_req, output lock);
endinterface

`default_nettype wire

// file: src/serial_frontend.sv
// Serial shift register on the link clock and its crossing to the core clock.
`timescale 1ns/100ps
`default_nettype none
`include "wiper_store_defines.svh"

module serial_frontend (
   // Core side
   input wire logic core_clk,
   input wire logic resetn,
   // Serial pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   output logic sdo_o,
   output logic sdo_oe,
   // Frame hand-over
   frame_if.front frm
);

   // ----------------------------------------------------------------
   // Link clock domain
   // ----------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic lock_held_q;
   logic [`WORD_MSB:0] shift_q;
   logic [`BIT_CNT_W-1:0] cnt_q;

   always_ff @(posedge sclk) begin
      rst_sync_q <= {rst_sync_q[0], resetn};
   end

   // The count only runs forward, so the core side measures a frame as the
   // difference between two snapshots and no reset at frame start is needed.
   always_ff @(posedge sclk) begin
      if (!rst_sync_q[1]) begin
         shift_q <= 16'h0000;
         cnt_q <= 8'h00;
      end else if (!cs_n && !lock_held_q) begin
         shift_q <= {shift_q[`WORD_MSB-1:0], sdi};
         cnt_q <= cnt_q + 8'h01;
      end
   end

   // Open-drain output: pulls low for a zero bit, released while deselected.
   assign sdo_o = 1'b0;
   assign sdo_oe = !cs_n && !shift_q[`WORD_MSB];

   // ----------------------------------------------------------------
   // Core clock domain
   // ----------------------------------------------------------------
   logic [2:0] cs_sync_q;
   logic [`BIT_CNT_W-1:0] base_q;
   logic [`BIT_CNT_W-1:0] bits;
   logic cs_rise;

   always_ff @(posedge core_clk) begin
      cs_sync_q <= {cs_sync_q[1:0], cs_n};
   end

   // The link clock stops between frames, so a synchroniser on its side would
   // never see the lock. The lock is instead held still while select is low;
   // the host must leave more than two core periods from select low to the
   // first link clock edge.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         lock_held_q <= 1'b0;
      end else if (cs_sync_q[1] && cs_sync_q[2]) begin
         lock_held_q <= frm.lock;
      end
   end

   assign cs_rise = cs_sync_q[1] && !cs_sync_q[2];
   // Shift register and count are still while select is high.
   assign bits = cnt_q - base_q;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         base_q <= 8'h00;
         frm.word <= 16'h0000;
         frm.frame_done <= 1'b0;
         frm.repeat_req <= 1'b0;
      end else begin
         frm.frame_done <= 1'b0;
         frm.repeat_req <= 1'b0;
         if (cs_rise) begin
            base_q <= cnt_q;
            frm.word <= shift_q;
            if (bits == 8'h00) begin
               frm.repeat_req <= 1'b1;
            end else if (bits[3:0] == 4'h0) begin
               frm.frame_done <= 1'b1;
            end
         end
      end
   end

endmodule // serial_frontend

`default_nettype wire

// file: src/setting_store.sv
// Two-entry nonvolatile setting store with its programming timer.
`timescale 1ns/100ps
`default_nettype none
`include "wiper_store_defines.svh"

module setting_store #(
   parameter int unsigned SAVE_CYCLES = `SAVE_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // Programming request
   input wire logic wr_en,
   input wire logic wr_sel,
   input wire wiper_store_pkg::wiper_t wr_data,
   // Stored values and status
   output wiper_store_pkg::wiper_t rd_ch1,
   output wiper_store_pkg::wiper_t rd_ch2,
   output logic busy,
   output logic done
);

   // Factory content is midscale; the array has no reset on purpose.
   wiper_store_pkg::wiper_t mem [0:1] = '{`WIPER_MID, `WIPER_MID};
   wiper_store_pkg::wiper_t pend_data_q;
   logic pend_sel_q;
   logic [31:0] timer_q;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         busy <= 1'b0;
         done <= 1'b0;
         timer_q <= 32'h0000_0000;
         pend_data_q <= `WIPER_ZERO;
         pend_sel_q <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!busy && wr_en) begin
            busy <= 1'b1;
            timer_q <= 32'h0000_0000;
            pend_data_q <= wr_data;
            pend_sel_q <= wr_sel;
         end else if (busy) begin
            if (timer_q == SAVE_CYCLES - 1) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               timer_q <= timer_q + 32'h0000_0001;
            end
         end
      end
   end

   // The cell takes its new value when programming ends.
   always_ff @(posedge core_clk) begin
      if (busy && timer_q == SAVE_CYCLES - 1) begin
         mem[pend_sel_q] <= pend_data_q;
      end
   end

   assign rd_ch1 = mem[0];
   assign rd_ch2 = mem[1];

endmodule // setting_store

`default_nettype wire

// file: sim/wiper_store_ctrl_chk.sv
// Concurrent checks on the ports of the wiper setting store control.
`timescale 1ns/100ps
`default_nettype none
`include "wiper_store_defines.svh"

module wiper_store_ctrl_chk #(
   parameter int unsigned SAVE_CYCLES = `SAVE_CYCLES
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic wp_n,
   input wire logic preset_reload_n,
   input wire logic rdy_o,
   input wire logic rdy_oe,
   input wire wiper_store_pkg::wiper_t wiper_tap_ch1,
   input wire wiper_store_pkg::wiper_t wiper_tap_ch2
);
   // ------------------------------------------------------------
   // Helper counters
   // ------------------------------------------------------------
   int unsigned rdy_cnt_q;
   logic [3:0] cs_lo_q;
   logic [3:0] pr_hi_q;
   logic [3:0] wp_lo_q;
   always_ff @(posedge core_clk) begin
      if (!resetn || !rdy_oe) rdy_cnt_q <= 0;
      else rdy_cnt_q <= rdy_cnt_q + 1;
   end
   always_ff @(posedge core_clk) begin
      if (!resetn || cs_n) cs_lo_q <= 4'h0;
      else if (cs_lo_q != 4'hF) cs_lo_q <= cs_lo_q + 4'h1;
   end
   always_ff @(posedge core_clk) begin
      if (!resetn || !preset_reload_n) pr_hi_q <= 4'h0;
      else if (pr_hi_q != 4'hF) pr_hi_q <= pr_hi_q + 4'h1;
   end
   always_ff @(posedge core_clk) begin
      if (!resetn || wp_n) wp_lo_q <= 4'h0;
      else if (wp_lo_q != 4'hF) wp_lo_q <= wp_lo_q + 4'h1;
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_save_length: assert property ($fell(rdy_oe) |-> rdy_cnt_q == SAVE_CYCLES + 1)
      else $error("ready low time differs from the save length");
   a_save_locks_taps: assert property (rdy_oe && $past(rdy_oe) && pr_hi_q > 4'h5
      |-> $stable(wiper_tap_ch1) && $stable(wiper_tap_ch2)) else $error("tap moved during save");
   a_save_after_strobe: assert property ($rose(rdy_oe) |-> cs_n && $past(cs_n, 2))
      else $error("save started while select was low");
   a_quiet_select_low: assert property (cs_lo_q > 4'h5 && pr_hi_q > 4'h5
      |-> $stable(wiper_tap_ch1) && $stable(wiper_tap_ch2)) else $error("tap moved in frame");
   a_protect_no_save: assert property (wp_lo_q > 4'h7 |-> !$rose(rdy_oe))
      else $error("save started under write protect");
   a_preset_mid: assert property ($fell(preset_reload_n) |-> ##[1:3]
      (wiper_tap_ch1 == `WIPER_MID && wiper_tap_ch2 == `WIPER_MID)) else $error("no midscale");
   a_sdo_off_idle: assert property (cs_n |-> !sdo_oe)
      else $error("serial output driven while deselected");
   a_pins_open_drain: assert property (sdo_o == 1'b0 && rdy_o == 1'b0)
      else $error("open drain pin drives high");
   a_boot_midscale: assert property ($rose(resetn)
      |-> wiper_tap_ch1 == `WIPER_MID && wiper_tap_ch2 == `WIPER_MID) else $error("bad reset tap");
endmodule // wiper_store_ctrl_chk

bind wiper_store_ctrl wiper_store_ctrl_chk #(.SAVE_CYCLES(SAVE_CYCLES)) chk_i (
   .core_clk(core_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
   .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wp_n(wp_n), .preset_reload_n(preset_reload_n),
   .rdy_o(rdy_o), .rdy_oe(rdy_oe), .wiper_tap_ch1(wiper_tap_ch1),
   .wiper_tap_ch2(wiper_tap_ch2));

`default_nettype wire

// file: sim/serial_host.sv
// Host model that drives the serial link and captures the serial output.
`timescale 1ns/100ps
`default_nettype none

module serial_host (
   // Serial pins
   output logic sclk,
   output logic cs_n,
   output logic sdi,
   input wire logic sdo_o,
   input wire logic sdo_oe
);
   logic [31:0] rx;
   wire logic sdo_line = sdo_oe ? sdo_o : 1'b1;
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
      rx = 32'h0;
   end
   task automatic idle_clk(input int n);
      repeat (2 * n) #7.5 sclk = ~sclk;
   endtask
   // The clock stands still between frames and data shows the inverse of its last bit.
   task automatic send(input logic [31:0] w, input int nb);
      cs_n = 1'b0;
      #30;
      for (int i = nb - 1; i >= 0; i--) begin
         sdi = w[i];
         #7.5;
         rx = {rx[30:0], sdo_line};
         sclk = 1'b1;
         #7.5;
         sclk = 1'b0;
      end
      #7.5;
      sdi = ~sdi;
      cs_n = 1'b1;
      #15;
   endtask
   task automatic strobe();
      cs_n = 1'b0;
      #30;
      cs_n = 1'b1;
      #15;
   endtask
endmodule // serial_host

`default_nettype wire

// file: sim/tb.sv
// Self-checking testbench of the dual wiper setting store control.
`timescale 1ns/100ps
`default_nettype none

module tb;
   // ------------------------------------------------------------
   // Pins, design, host and model state
   // ------------------------------------------------------------
   localparam int unsigned SAVE = 60;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic wp_n = 1'b1;
   logic preset_reload_n = 1'b1;
   wire logic sclk, cs_n, sdi, sdo_o, sdo_oe, rdy_o, rdy_oe;
   wiper_store_pkg::wiper_t tap1, tap2;
   int n_fail = 0;
   int samples_checked = 0;
   int m[2] = '{8'h80, 8'h80};
   int st[2] = '{8'h80, 8'h80};
   int last = 0;
   int wp = 1;
   int q[$];
   logic [3:0] ops[14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hB, 4'hC,
                          4'hD, 4'hE, 4'hF};
   always #5 core_clk = ~core_clk;
   wiper_store_ctrl #(.SAVE_CYCLES(SAVE)) wiper_store_ctrl_i (
      .core_clk(core_clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
      .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wp_n(wp_n), .preset_reload_n(preset_reload_n),
      .rdy_o(rdy_o), .rdy_oe(rdy_oe), .wiper_tap_ch1(tap1), .wiper_tap_ch2(tap2));
   serial_host serial_host_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o),
      .sdo_oe(sdo_oe));
   // ------------------------------------------------------------
   // Model and tasks
   // ------------------------------------------------------------
   function automatic int stepv(int op, int v);
      case (op | 1)
         5: return v >> 1;
         7: return (v == 0) ? 0 : v - 1;
         13: return v[7] ? 8'hFF : (v << 1) & 8'hFF;
         default: return (v == 8'hFF) ? v : v + 1;
      endcase
   endfunction
   function automatic void exec(int w);
      int op, a;
      op = (w >> 12) & 15;
      a = (w >> 8) & 1;
      last = w;
      if (wp == 0 && !(op inside {0, 1, 8, 9, 10})) return;
      case (op)
         1: m[a] = st[a];
         2: st[a] = m[a];
         3: st[a] = w & 8'hFF;
         8: m = st;
         11: m[a] = w & 8'hFF;
         4, 6, 12, 14: m[a] = stepv(op, m[a]);
         5, 7, 13, 15: foreach (m[i]) m[i] = stepv(op, m[i]);
         default: ;
      endcase
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic taps();
      check(tap1, m[0]);
      check(tap2, m[1]);
   endtask
   task automatic settle();
      int n;
      n = 0;
      repeat (8) @(negedge core_clk);
      while (rdy_oe !== 1'b0 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      check(n < 200, 1);
      repeat (2) @(negedge core_clk);
   endtask
   task automatic frame(input int w, input int nb);
      serial_host_i.send(w, nb);
      if (nb % 16 == 0) exec(w & 16'hFFFF);
      settle();
   endtask
   task automatic strobe();
      serial_host_i.strobe();
      if (((last >> 12) & 15) inside {4, 5, 6, 7, 12, 13, 14, 15}) exec(last);
      settle();
   endtask
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      #400000;
      n_fail++;
      print_verdict();
   end
   initial begin
      void'($urandom(73));
      fork
         serial_host_i.idle_clk(8);
         repeat (4) @(negedge core_clk);
      join
      resetn = 1'b1;
      // The link side leaves reset only on link clock edges.
      fork
         serial_host_i.idle_clk(4);
         repeat (4) @(negedge core_clk);
      join
      taps();
      frame(32'hB040, 16);
      taps();
      frame(32'h2000, 16);
      check(serial_host_i.rx[15:0], 32'hB040);
      frame(32'hB180, 16);
      frame(32'h2100, 16);
      check(serial_host_i.rx[15:0], 32'hB180);
      frame(32'hB011, 16);
      frame(32'h8000, 16);
      taps();
      frame(32'h1234B155, 32);
      check(serial_host_i.rx, 32'h80001234);
      taps();
      $display("test write save daisy done");
      serial_host_i.send(32'h2000, 16);
      exec(32'h2000);
      repeat (8) @(negedge core_clk);
      check(rdy_oe, 1);
      serial_host_i.send(32'hB1FF, 16);
      settle();
      taps();
      frame(32'h5855, 15);
      taps();
      $display("test refusals done");
      frame(32'hB0FF, 16);
      frame(32'hE000, 16);
      taps();
      frame(32'hB100, 16);
      frame(32'h6100, 16);
      taps();
      frame(32'hE100, 16);
      strobe();
      strobe();
      taps();
      foreach (ops[i]) q.push_back({ops[i], 4'($urandom % 2), 8'($urandom)});
      repeat (30) q.push_back({ops[$urandom % 14], 4'($urandom % 2), 8'($urandom)});
      while (q.size() > 0) begin
         if ($urandom % 4 == 0) strobe();
         frame(q.pop_front(), 16);
         taps();
      end
      $display("test commands done");
      wp_n = 1'b0;
      wp = 0;
      frame(32'hB012, 16);
      frame(32'hF000, 16);
      frame(32'h2000, 16);
      taps();
      frame(32'h8000, 16);
      taps();
      frame(32'h0000, 16);
      wp_n = 1'b1;
      wp = 1;
      $display("test protect done");
      frame(32'hB0C3, 16);
      preset_reload_n = 1'b0;
      repeat (5) @(negedge core_clk);
      check(tap1, 8'h80);
      check(tap2, 8'h80);
      preset_reload_n = 1'b1;
      repeat (6) @(negedge core_clk);
      m = st;
      taps();
      $display("test preset done");
      print_verdict();
   end
endmodule // tb

`default_nettype wire
